//--- inc/aid_map.svh
// register offsets, field positions, reset values and timing constants for
// the activity/inactivity detector; assumes a byte-wide register port
`ifndef AID_MAP_SVH
`define AID_MAP_SVH
`define AID_ADDR_MOTION_THR_X_LOW  8'h25
`define AID_ADDR_MOTION_THR_Y      8'h26
`define AID_ADDR_MOTION_THR_Z      8'h27
`define AID_ADDR_ACT_DURATION      8'h29
`define AID_ADDR_STILL_THR_X_LOW   8'h2c
`define AID_ADDR_STILL_THR_Y       8'h2d
`define AID_ADDR_STILL_THR_Z       8'h2e
`define AID_ADDR_INACT_DUR_HIGH    8'h30
`define AID_ADDR_INACT_DUR_LOW     8'h31
`define AID_ADDR_EVENT_CTL         8'h3c
`define AID_ADDR_EVENT_EVENT_STATUS_SECOND     8'h3d
`define AID_ADDR_POWER_MODE        8'h3e
`define AID_REF_SEL_BIT            0
`define AID_AXIS_EN_BIT            1
`define AID_LINK_BIT               0
`define AID_LOOP_BIT               1
`define AID_AUTOSLEEP_BIT          2
`define AID_FAST_RATE_BIT          3
`define AID_STAT_ACT_BIT           0
`define AID_STAT_INACT_BIT         1
`define AID_STAT_AWAKE_BIT         2
`define AID_RST_BYTE               8'h00
`define AID_RST_THR                12'h000
// timer ticks: nanoseconds of the printed tick over the 5 ns clock period;
// nanoseconds keep the longest tick inside 32 bits
`define AID_CLK_NS                 32'd5
`define AID_ACT_TICK_NS            32'd8250000
`define AID_ACT_TICK_FAST_NS       32'd4125000
`define AID_INACT_TICK_NS          32'd32500000
`define AID_ONE_TICK               24'h000001
`define AID_ZERO_TICK              24'h000000
`endif

//--- inc/aid_pkg.sv
// types shared by the activity/inactivity detector
package aid_pkg;
   typedef enum logic [1:0] {
      AID_STANDBY = 2'b00,
      AID_MEASURE = 2'b01,
      AID_WAKEUP  = 2'b10
   } aid_mode_e;
   typedef logic [11:0] aid_sample_t;
endpackage

//--- logic/aid_detector.sv
// activity and inactivity detection on per-axis acceleration samples
// assumes samples arrive as one-cycle strobes on the 200 MHz clock and the
// register port is written/read by logic on the same clock
`timescale 1ns/1ps
`include "aid_map.svh"

// Functional notes
// - one activity reference-select bit in x low activity threshold, all axes
// - absolute activity compares raw sample magnitude to axis threshold
// - referenced activity uses abs(sample minus reference) above threshold
// - reset selects absolute; reference captured on entering measurement
// - new reference only after both selects return absolute, then one referenced
// - activity tick 8.25 ms, or 4.125 ms at the fastest sample rate
// - activity needs duration ticks above threshold; zero means one sample
// - activity timer counts only in measurement mode
// - wake-up mode uses single-sample activity and enters measurement
// - after wake-up, interrupt at once only when duration is zero
// - awake high in measurement for default/autosleep, else follows activity
// - inactivity needs all enabled axes at or below threshold, shared timer
// - separate inactivity reference-select bit in x low inactivity register
// - absolute inactivity needs consecutive quiet samples for duration
// - referenced inactivity quiet when deviation within threshold
// - inactivity tick 32.5 ms at every rate
// - inactivity duration is sixteen bits over two registers
// - default, linked, loop and autosleep interaction in both modes
// - each event stays set until read or a measurement start, then may fire again
// - any one enabled axis above threshold counts as activity
// - status read clears events except default mode with zero duration
module aid_detector
   import aid_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // sample stream
   input  wire logic        sample_valid,
   input  wire aid_sample_t sample_x,
   input  wire aid_sample_t sample_y,
   input  wire aid_sample_t sample_z,
   // register port
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // status
   output logic             activity_event,
   output logic             inactivity_event,
   output logic             awake,
   output logic [1:0]       power_mode
);
   // tick lengths in clock cycles; the longest fits the 24-bit dividers
   localparam int ACT_CYC  = `AID_ACT_TICK_NS / `AID_CLK_NS;
   localparam int ACTF_CYC = `AID_ACT_TICK_FAST_NS / `AID_CLK_NS;
   localparam int INA_CYC  = `AID_INACT_TICK_NS / `AID_CLK_NS;

   // registers
   aid_sample_t act_thr [3];
   aid_sample_t ina_thr [3];
   logic [2:0]  act_en;
   logic [2:0]  ina_en;
   logic        motion_reference_select;
   logic        still_reference_select;
   logic [7:0]  activity_duration;
   logic [7:0]  inactivity_duration_high;
   logic [7:0]  inactivity_duration_low;
   logic [3:0]  event_ctl;
   aid_mode_e   mode;
   aid_sample_t ref_val [3];
   logic        ref_armed;
   logic [23:0] act_div;
   logic [23:0] ina_div;
   logic [7:0]  act_ticks;
   logic [15:0] ina_ticks;
   logic        seek_act;

   // absolute magnitude of a signed 12-bit sample, or deviation from ref
   function automatic aid_sample_t mag(input aid_sample_t a,
                                       input aid_sample_t r,
                                       input logic use_ref);
      aid_sample_t d;
      d = use_ref ? aid_sample_t'(a - r) : a;
      mag = d[11] ? aid_sample_t'(~d + 12'h001) : d;
   endfunction

   // reference in use: a sample taken for capture is measured against
   // itself, so it can never trip against the stale or reset reference
   wire              ref_take = ref_armed & (mode == AID_MEASURE);
   wire aid_sample_t ref_x    = ref_take ? sample_x : ref_val[0];
   wire aid_sample_t ref_y    = ref_take ? sample_y : ref_val[1];
   wire aid_sample_t ref_z    = ref_take ? sample_z : ref_val[2];

   // deviation of each axis in the activity and in the inactivity sense
   wire aid_sample_t act_dx = mag(sample_x, ref_x, motion_reference_select);
   wire aid_sample_t act_dy = mag(sample_y, ref_y, motion_reference_select);
   wire aid_sample_t act_dz = mag(sample_z, ref_z, motion_reference_select);
   wire aid_sample_t ina_dx = mag(sample_x, ref_x, still_reference_select);
   wire aid_sample_t ina_dy = mag(sample_y, ref_y, still_reference_select);
   wire aid_sample_t ina_dz = mag(sample_z, ref_z, still_reference_select);

   // per-axis comparisons; a disabled axis never trips and never blocks
   wire [2:0] over;
   wire [2:0] quiet;
   assign over[0]  = act_en[0] & (act_dx > act_thr[0]);
   assign over[1]  = act_en[1] & (act_dy > act_thr[1]);
   assign over[2]  = act_en[2] & (act_dz > act_thr[2]);
   assign quiet[0] = ~ina_en[0] | (ina_dx <= ina_thr[0]);
   assign quiet[1] = ~ina_en[1] | (ina_dy <= ina_thr[1]);
   assign quiet[2] = ~ina_en[2] | (ina_dz <= ina_thr[2]);

   wire any_over    = |over;
   wire all_quiet   = &quiet & |ina_en;
   wire linked      = event_ctl[`AID_LINK_BIT] | event_ctl[`AID_LOOP_BIT];
   wire loop_mode   = event_ctl[`AID_LOOP_BIT];
   wire autosleep   = event_ctl[`AID_AUTOSLEEP_BIT];
   wire fast_rate   = event_ctl[`AID_FAST_RATE_BIT];
   wire [15:0] ina_need = {inactivity_duration_high, inactivity_duration_low};
   wire [23:0] act_period = fast_rate ? 24'(ACTF_CYC) : 24'(ACT_CYC);
   wire act_tick = (act_div == act_period - `AID_ONE_TICK);
   wire ina_tick = (ina_div == 24'(INA_CYC) - `AID_ONE_TICK);
   wire measuring = (mode == AID_MEASURE);
   wire look_act   = ~linked | seek_act;
   wire look_ina   = ~linked | ~seek_act;
   wire act_hit = sample_valid & any_over & look_act & measuring &
                  ((activity_duration == `AID_RST_BYTE) ||
                   (act_ticks >= activity_duration));
   wire wake_hit = sample_valid & any_over & (mode == AID_WAKEUP);
   wire ina_hit = sample_valid & all_quiet & look_ina & measuring &
                  ((ina_need == 16'h0000) || (ina_ticks >= ina_need));
   // a zero duration in default mode keeps its event until a restart
   wire sticky_act = ~linked & (activity_duration == `AID_RST_BYTE);
   wire sticky_ina = ~linked & (ina_need == 16'h0000);
   // a wake-up reports activity at once only with a zero duration
   wire wake_report = (activity_duration == `AID_RST_BYTE);
   wire st_read = reg_read & (reg_addr == `AID_ADDR_EVENT_EVENT_STATUS_SECOND);
   wire mode_wr = reg_write & (reg_addr == `AID_ADDR_POWER_MODE);
   wire enter_meas = (mode_wr & (reg_wdata[1:0] == AID_MEASURE) & ~measuring)
                     | wake_hit;
   wire cfg_ok = (mode == AID_STANDBY); // settings are only taken in standby

   // configuration registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 3; i++) begin
            act_thr[i] <= `AID_RST_THR;
            ina_thr[i] <= `AID_RST_THR;
         end
         act_en <= 3'h0;
         ina_en <= 3'h0;
         motion_reference_select <= 1'b0;
         still_reference_select  <= 1'b0;
         activity_duration <= `AID_RST_BYTE;
         inactivity_duration_high <= `AID_RST_BYTE;
         inactivity_duration_low  <= `AID_RST_BYTE;
         event_ctl <= 4'h0;
      end else if (reg_write & cfg_ok) begin
         unique case (reg_addr)
            `AID_ADDR_MOTION_THR_X_LOW: begin
               act_thr[0][7:0] <= reg_wdata;
               motion_reference_select <= reg_wdata[`AID_REF_SEL_BIT];
               act_en[0] <= reg_wdata[`AID_AXIS_EN_BIT];
            end
            `AID_ADDR_MOTION_THR_Y: act_thr[1][7:0] <= reg_wdata;
            `AID_ADDR_MOTION_THR_Z: act_thr[2][7:0] <= reg_wdata;
            `AID_ADDR_ACT_DURATION: activity_duration <= reg_wdata;
            `AID_ADDR_STILL_THR_X_LOW: begin
               ina_thr[0][7:0] <= reg_wdata;
               still_reference_select <= reg_wdata[`AID_REF_SEL_BIT];
               ina_en[0] <= reg_wdata[`AID_AXIS_EN_BIT];
            end
            `AID_ADDR_STILL_THR_Y: ina_thr[1][7:0] <= reg_wdata;
            `AID_ADDR_STILL_THR_Z: ina_thr[2][7:0] <= reg_wdata;
            `AID_ADDR_INACT_DUR_HIGH: inactivity_duration_high <= reg_wdata;
            `AID_ADDR_INACT_DUR_LOW:  inactivity_duration_low <= reg_wdata;
            `AID_ADDR_EVENT_CTL: event_ctl <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // reference capture: armed by absolute, taken on measurement entry
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ref_armed <= 1'b1;
         for (int i = 0; i < 3; i++) ref_val[i] <= `AID_RST_THR;
      end else if (~motion_reference_select & ~still_reference_select) begin
         ref_armed <= 1'b1;
      end else if (ref_armed & measuring & sample_valid) begin
         ref_armed <= 1'b0;
         ref_val[0] <= sample_x;
         ref_val[1] <= sample_y;
         ref_val[2] <= sample_z;
      end
   end

   // power mode and wake-up handover
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mode <= AID_STANDBY;
      end else if (wake_hit) begin
         mode <= AID_MEASURE;
      end else if (autosleep & ina_hit) begin
         mode <= AID_WAKEUP;
      end else if (mode_wr & (reg_wdata[1:0] != 2'b11)) begin
         mode <= aid_mode_e'(reg_wdata[1:0]);
      end
   end

   // shared tick dividers, free-running in measurement, and duration counters restarted on a break
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         act_div <= `AID_ZERO_TICK;
         ina_div <= `AID_ZERO_TICK;
         act_ticks <= 8'h00;
         ina_ticks <= 16'h0000;
      end else begin
         act_div <= (~measuring | act_tick) ? `AID_ZERO_TICK
                    : act_div + `AID_ONE_TICK;
         ina_div <= (~measuring | ina_tick) ? `AID_ZERO_TICK
                    : ina_div + `AID_ONE_TICK;
         if (~measuring | (sample_valid & ~any_over) | act_hit)
            act_ticks <= 8'h00;
         else if (act_tick & act_ticks != 8'hff)
            act_ticks <= act_ticks + 8'h01;
         if (~measuring | (sample_valid & ~all_quiet) | ina_hit)
            ina_ticks <= 16'h0000;
         else if (ina_tick & ina_ticks != 16'hffff)
            ina_ticks <= ina_ticks + 16'h0001;
      end
   end

   // sticky events; a new hit wins over a clearing read
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         activity_event <= 1'b0;
         inactivity_event <= 1'b0;
         seek_act <= 1'b1;
         awake <= 1'b0;
      end else begin
         if (act_hit | (wake_hit & wake_report))
            activity_event <= 1'b1;
         else if ((st_read & ~sticky_act) | enter_meas)
            activity_event <= 1'b0;
         if (ina_hit)
            inactivity_event <= 1'b1;
         else if ((st_read & ~sticky_ina) | enter_meas)
            inactivity_event <= 1'b0;
         // a wake-up looks for stillness next, a manual start for motion
         if (act_hit | wake_hit) seek_act <= 1'b0;
         else if (ina_hit | enter_meas) seek_act <= 1'b1;
         if (~linked | autosleep)
            awake <= measuring | enter_meas;
         else if (act_hit) awake <= 1'b1;
         else if (ina_hit) awake <= 1'b0;
      end
   end

   // status read data, registered; unmapped offsets read as zero
   wire [7:0] status_byte = {5'h00, awake, inactivity_event, activity_event};
   wire [7:0] read_byte =
      (reg_addr == `AID_ADDR_EVENT_EVENT_STATUS_SECOND)  ? status_byte :
      (reg_addr == `AID_ADDR_ACT_DURATION)   ? activity_duration :
      (reg_addr == `AID_ADDR_INACT_DUR_HIGH) ? inactivity_duration_high :
      (reg_addr == `AID_ADDR_INACT_DUR_LOW)  ? inactivity_duration_low :
      `AID_RST_BYTE;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) reg_rdata <= `AID_RST_BYTE;
      else if (reg_read) reg_rdata <= read_byte;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) power_mode <= 2'b00;
      else power_mode <= mode;
   end
endmodule

//--- test/aid_detector_asserts.sv
// port-level checks for the activity/inactivity detector
// assumes one clock domain and a bind from the bench top
`timescale 1ns/1ps
module aid_detector_asserts
   import aid_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // watched ports
   input wire logic        sample_valid,
   input wire aid_sample_t sample_x,
   input wire aid_sample_t sample_y,
   input wire aid_sample_t sample_z,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        activity_event,
   input wire logic        inactivity_event,
   input wire logic        awake,
   input wire logic [1:0]  power_mode
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // in measurement, events hold unless a status read or a mode write can clear them
   act_hold_a: assert property (activity_event && power_mode == AID_MEASURE
      && !(reg_read && reg_addr == 8'h3d) && !(reg_write && reg_addr == 8'h3e)
      |=> activity_event) else $error("activity event dropped");
   inact_hold_a: assert property (inactivity_event && power_mode == 2'h1
      && !(reg_read && reg_addr == 8'h3d) && !(reg_write && reg_addr == 8'h3e)
      |=> inactivity_event) else $error("inactivity event dropped");
   act_cause_a: assert property ($rose(activity_event) |-> $past(sample_valid))
      else $error("activity event without a sample");
   inact_cause_a: assert property ($rose(inactivity_event)
      |-> $past(sample_valid)) else $error("inactivity event without a sample");
   status_view_a: assert property (reg_read && reg_addr == 8'h3d |=>
      reg_rdata[1:0] == {$past(inactivity_event), $past(activity_event)})
      else $error("status read does not show events");
   rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   mode_legal_a: assert property (power_mode != 2'h3)
      else $error("illegal power mode");
   bad_mode_a: assert property (reg_write && reg_addr == 8'h3e
      && reg_wdata == 8'h03 && !sample_valid |-> ##2 $stable(power_mode))
      else $error("mode code 3 accepted");
   mode_cause_a: assert property ($changed(power_mode) |-> $past(reg_write)
      || $past(reg_write, 2) || $past(sample_valid) || $past(sample_valid, 2))
      else $error("power mode changed on its own");
endmodule

//--- test/aid_detector_test.sv
// self-checking bench for the activity/inactivity detector
// assumes zero durations, since the real ticks are 825,000 cycles or more
`timescale 1ns/1ps
module aid_detector_test;
   import aid_pkg::*;
   logic        clock, reset, sample_valid, reg_write, reg_read;
   aid_sample_t sample_x, sample_y, sample_z;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
   logic        activity_event, inactivity_event, awake;
   logic [1:0]  power_mode;
   int          mismatches = 0;
   int          checks_done = 0;
   aid_detector u_dut (.clock(clock), .reset(reset),
      .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
      .sample_z(sample_z), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .activity_event(activity_event), .inactivity_event(inactivity_event),
      .awake(awake), .power_mode(power_mode));
   aid_host u_host (.clock(clock), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // one-cycle sample strobe on x; y and z stay disabled
   task automatic send(input aid_sample_t x);
      @(posedge clock);
      #1;
      sample_x = x;
      sample_valid = 1'b1;
      cyc(1);
      sample_valid = 1'b0;
      cyc(1);
   endtask
   task automatic mode(input logic [7:0] m);
      u_host.wr(8'h3e, m);
      cyc(3);
   endtask
   task automatic t_regs();
      logic [7:0] a[3] = '{8'h29, 8'h30, 8'h31};
      foreach (a[i]) begin
         u_host.rd(a[i], v);
         chk("duration reset", v, 8'h00);
      end
      foreach (a[i]) u_host.wr(a[i], a[i] ^ 8'hff);
      foreach (a[i]) begin
         u_host.rd(a[i], v);
         chk("duration rw", v, a[i] ^ 8'hff);
         u_host.wr(a[i], 8'h00);
      end
   endtask
   // absolute detection, sticky events, zero-duration clearing
   task automatic t_abs();
      u_host.wr(8'h25, 8'h42);
      u_host.wr(8'h2c, 8'h42);
      mode(8'h01);
      send(12'h7ff);
      chk("act abs", activity_event, 1'b1);
      chk("awake", awake, 1'b1);
      send(12'h000);
      chk("inact abs", inactivity_event, 1'b1);
      chk("act sticky", activity_event, 1'b1);
      u_host.rd(8'h3d, v);
      chk("event_status_second", v[1:0], 8'h03);
      chk("act kept", activity_event, 1'b1);
      u_host.wr(8'h29, 8'h05);
      mode(8'h03);
      chk("mode 3", power_mode, 2'h1);
      mode(8'h00);
      mode(8'h01);
      chk("act restart", activity_event, 1'b0);
      mode(8'h00);
      u_host.rd(8'h29, v);
      chk("locked cfg", v, 8'h00);
   endtask
   // first measured sample becomes the reference
   task automatic t_ref();
      u_host.wr(8'h25, 8'h43);
      mode(8'h01);
      send(12'h7ff);
      send(12'h7ff);
      chk("ref quiet", activity_event, 1'b0);
      send(12'h000);
      chk("ref act", activity_event, 1'b1);
      mode(8'h00);
      u_host.wr(8'h25, 8'h42);
   endtask
   task automatic t_wake();
      int n;
      mode(8'h02);
      chk("wake mode", power_mode, 2'h2);
      send(12'h7ff);
      for (n = 0; n < 20 && power_mode !== 2'h1; n++) cyc(1);
      if (n == 20) begin
         chk("wake exit", power_mode, 2'h1);
         return;
      end
      chk("wake act", activity_event, 1'b1);
      chk("wake awake", awake, 1'b1);
      mode(8'h02);
   endtask
   // linked hand-off between the two detectors, then autosleep return
   task automatic t_link();
      mode(8'h00);
      u_host.wr(8'h3c, 8'h01);
      mode(8'h01);
      send(12'h000);
      chk("link ina off", inactivity_event, 1'b0);
      send(12'h7ff);
      chk("link act", activity_event, 1'b1);
      chk("link awake", awake, 1'b1);
      send(12'h000);
      chk("link ina", inactivity_event, 1'b1);
      chk("link asleep", awake, 1'b0);
      u_host.rd(8'h3d, v);
      chk("link status", v, 8'h03);
      chk("link clear", activity_event, 1'b0);
      mode(8'h00);
      u_host.wr(8'h3c, 8'h04);
      mode(8'h02);
      send(12'h7ff);
      send(12'h000);
      chk("autosleep", power_mode, 2'h2);
      chk("auto asleep", awake, 1'b0);
      mode(8'h00);
   endtask
   initial begin
      reset = 1'b1;
      sample_valid = 1'b0;
      sample_x = 12'h000;
      sample_y = 12'h000;
      sample_z = 12'h000;
      cyc(20);
      reset = 1'b0;
      chk("mode reset", power_mode, 2'h0);
      t_regs();
      t_abs();
      t_ref();
      t_wake();
      t_link();
      close_out();
   end
endmodule
bind aid_detector aid_detector_asserts u_chk (.clock(clock), .reset(reset),
   .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
   .sample_z(sample_z), .reg_write(reg_write), .reg_read(reg_read),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .activity_event(activity_event), .inactivity_event(inactivity_event),
   .awake(awake), .power_mode(power_mode));

//--- test/aid_host.sv
// host model: byte register writes and reads toward the detector
// assumes strobes are sampled on the rising edge of clock
`timescale 1ns/1ps
module aid_host (
   // clock
   input  wire logic       clock,
   // register port
   output logic            reg_write,
   output logic            reg_read,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // idle bus from time zero
   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // config writes belong in standby; callers keep to that except on purpose
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clock);
      #1;
      reg_write = 1'b0;
   endtask
   // data taken one edge late so either read latency is settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge clock);
      #1;
      reg_read = 1'b0;
      @(posedge clock);
      #1;
      d = reg_rdata;
   endtask
endmodule
